// [design/cfg_regs_pkg.sv]
// Package: offsets, fields, reset values and carriers for the config register group.
// Assumes an 8-bit register port with a 12-bit address, driven by the serial control logic.
package cfg_regs_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] OFF_INTF_CFG = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_CATEGORY = 12'h003;
	localparam logic [ADDR_W-1:0] OFF_PID_LO = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_PID_HI = 12'h005;
	localparam logic [ADDR_W-1:0] OFF_GRADE_REV = 12'h006;
	localparam logic [ADDR_W-1:0] OFF_PAGE = 12'h008;
	localparam logic [ADDR_W-1:0] PG0_LO = 12'h013;
	localparam logic [ADDR_W-1:0] PG0_HI = 12'h014;
	localparam logic [ADDR_W-1:0] PG1_LO = 12'h034;
	localparam logic [ADDR_W-1:0] PG1_HI = 12'h03D;
	localparam logic [ADDR_W-1:0] PG2_LO = 12'h110;
	localparam logic [ADDR_W-1:0] PG2_HI = 12'h124;
	localparam logic [ADDR_W-1:0] PG3_LO = 12'h135;
	localparam logic [ADDR_W-1:0] PG3_HI = 12'h14C;
	localparam int BIT_ORDER_POS = 1;
	localparam int SOFT_RST_POS = 0;
	localparam logic [1:0] PAGE_RST = 2'h3;
	localparam logic [1:0] PAGE_CONV0 = 2'h1;
	localparam logic [1:0] PAGE_CONV1 = 2'h2;
	localparam logic [1:0] PAGE_BOTH = 2'h3;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [3:0] SRST_CYCLES = 4'h4;
	localparam logic [3:0] SRST_ONE = 4'h1;
	localparam logic [3:0] SRST_IDLE = 4'h0;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;
	typedef struct packed {
		logic conv0;
		logic conv1;
	} conv_sel_s;
	typedef enum logic [1:0] {
		SR_IDLE = 2'b00,
		SR_BUSY = 2'b01,
		SR_DONE = 2'b11
	} srst_state_e;
endpackage

// [design/dac_config_id_paging_regs.sv]
// Device configuration group: bit order, soft reset, identity and converter paging.
// Assumes the serial port presents one-cycle rd/wr strobes synchronous to clk.
`timescale 1ns/1ps
// Function
// R1 - Bit order select, one means LSB first
// R2 - Soft reset trigger, clears itself when done
// R3 - Read-only category, product ID, grade, revision
// R4 - Page selects converter 0, 1 or both
// R5 - Paging only affects listed paged ranges
// R6 - Reserved bits read zero, writes ignored
module dac_config_id_paging_regs #(
	parameter logic [7:0] CATEGORY_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] PID_LO_CODE = 8'h12, // arbitrary value
	parameter logic [7:0] PID_HI_CODE = 8'h34, // arbitrary value
	parameter logic [3:0] GRADE_CODE = 4'h1, // arbitrary value
	parameter logic [3:0] REVISION_CODE = 4'h2 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire cfg_regs_pkg::reg_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic serial_bit_order_select,
	output logic soft_reset_active,
	output cfg_regs_pkg::conv_sel_s wr_sel,
	output cfg_regs_pkg::conv_sel_s rd_sel
);
	import cfg_regs_pkg::*;

	// ==========================================================
	// Decode
	wire logic hit_intf = req.addr == OFF_INTF_CFG;
	wire logic hit_page = req.addr == OFF_PAGE;
	wire logic hit_id = (req.addr >= OFF_CATEGORY) && (req.addr <= OFF_GRADE_REV);
	wire logic mapped = hit_intf || hit_page || hit_id;
	wire logic [3:0] range_hit;
	wire logic paged = |range_hit;
	page_range_match #(.LO(PG0_LO), .HI(PG0_HI)) u_r0 (.addr(req.addr), .hit(range_hit[0]));
	page_range_match #(.LO(PG1_LO), .HI(PG1_HI)) u_r1 (.addr(req.addr), .hit(range_hit[1]));
	page_range_match #(.LO(PG2_LO), .HI(PG2_HI)) u_r2 (.addr(req.addr), .hit(range_hit[2]));
	page_range_match #(.LO(PG3_LO), .HI(PG3_HI)) u_r3 (.addr(req.addr), .hit(range_hit[3]));

	// ==========================================================
	// Control registers
	logic bit_order_q;
	logic [1:0] page_q;
	srst_state_e sr_q, sr_d;
	logic [3:0] sr_cnt_q, sr_cnt_d;
	wire logic wr_intf = req.wr && hit_intf;
	wire logic srst_go = wr_intf && req.wdata[SOFT_RST_POS] && (sr_q == SR_IDLE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_order_q <= 1'b0;
		end else if (clk_en && wr_intf) begin
			bit_order_q <= req.wdata[BIT_ORDER_POS]; // [R1]
		end
	end

	// Soft reset also returns the page field to its default
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			page_q <= PAGE_RST;
		end else if (clk_en) begin
			if (sr_q == SR_DONE) begin
				page_q <= PAGE_RST;
			end else if (req.wr && hit_page) begin
				page_q <= req.wdata[1:0]; // [R4] [R6]
			end
		end
	end

	always_comb begin
		sr_d = sr_q;
		sr_cnt_d = sr_cnt_q;
		case (sr_q)
			SR_IDLE: begin
				if (srst_go) begin
					sr_d = SR_BUSY; // [R2]
					sr_cnt_d = SRST_CYCLES;
				end
			end
			SR_BUSY: begin
				sr_cnt_d = sr_cnt_q - SRST_ONE;
				if (sr_cnt_q == SRST_ONE) begin
					sr_d = SR_DONE;
				end
			end
			SR_DONE: begin
				sr_d = SR_IDLE; // [R2]
				sr_cnt_d = SRST_IDLE;
			end
			default: begin
				sr_d = SR_IDLE;
				sr_cnt_d = SRST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sr_q <= SR_IDLE;
			sr_cnt_q <= SRST_IDLE;
		end else if (clk_en) begin
			sr_q <= sr_d;
			sr_cnt_q <= sr_cnt_d;
		end
	end

	// ==========================================================
	// Page steering, registered so outputs are flops
	wire logic sel0 = page_q[0];
	wire logic sel1 = page_q[1];
	wire conv_sel_s only_conv0 = conv_sel_s'{conv0: 1'b1, conv1: 1'b0};
	wire conv_sel_s only_conv1 = conv_sel_s'{conv0: 1'b0, conv1: 1'b1};
	// Unpaged accesses default to converter 0 on both paths
	wire conv_sel_s wr_sel_d = paged ? conv_sel_s'{conv0: sel0, conv1: sel1}
		: only_conv0; // [R5]
	wire logic rd1_only = (page_q == PAGE_CONV1);
	wire conv_sel_s rd_sel_d = (paged && rd1_only) ? only_conv1 : only_conv0; // [R4] [R5]

	// ==========================================================
	// Read mux
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = ZERO_BYTE; // [R6]
		case (req.addr)
			OFF_INTF_CFG: rd_mux = {6'h00, bit_order_q, sr_q != SR_IDLE}; // [R2]
			OFF_CATEGORY: rd_mux = CATEGORY_CODE; // [R3]
			OFF_PID_LO: rd_mux = PID_LO_CODE; // [R3]
			OFF_PID_HI: rd_mux = PID_HI_CODE; // [R3]
			OFF_GRADE_REV: rd_mux = {GRADE_CODE, REVISION_CODE}; // [R3]
			OFF_PAGE: rd_mux = {6'h00, page_q}; // [R6]
			default: rd_mux = ZERO_BYTE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= ZERO_BYTE;
			rvalid <= 1'b0;
			serial_bit_order_select <= 1'b0;
			soft_reset_active <= 1'b0;
			wr_sel <= '{conv0: 1'b1, conv1: 1'b0};
			rd_sel <= '{conv0: 1'b1, conv1: 1'b0};
		end else if (clk_en) begin
			rvalid <= req.rd;
			if (req.rd) begin
				rdata <= rd_mux;
			end
			serial_bit_order_select <= bit_order_q; // [R1]
			soft_reset_active <= (sr_d != SR_IDLE); // [R2]
			wr_sel <= wr_sel_d;
			rd_sel <= rd_sel_d;
		end
	end

	// ==========================================================
	// Checks
	sequence s_srst_kick;
		srst_go;
	endsequence
	sequence s_srst_run;
		soft_reset_active [*4];
	endsequence

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !clk_en);

	a_srst_clears: assert property (s_srst_kick |=> s_srst_run ##[1:3] !soft_reset_active) // [R2]
		else $error("soft reset did not self clear");
	a_order_follow: assert property (wr_intf |=> ##1 // [R1]
		serial_bit_order_select == $past(req.wdata[BIT_ORDER_POS], 2))
		else $error("bit order output wrong");
	a_id_read: assert property (req.rd && req.addr == OFF_CATEGORY |=> rdata == CATEGORY_CODE) // [R3]
		else $error("category read wrong");
	a_grade_read: assert property (req.rd && req.addr == OFF_GRADE_REV |=>
		rdata == {GRADE_CODE, REVISION_CODE}) // [R3]
		else $error("grade read wrong");
	a_page_resv: assert property (req.rd && req.addr == OFF_PAGE |=> rdata[7:2] == 6'h00) // [R6]
		else $error("page reserved bits nonzero");
	a_unpaged_conv0: assert property (!paged |=> wr_sel == only_conv0) // [R5]
		else $error("unpaged access steered");
	a_both_write: assert property (paged && page_q == PAGE_BOTH |=> wr_sel.conv0 && wr_sel.conv1) // [R4]
		else $error("both page not writing both");
	a_both_read0: assert property (paged && page_q == PAGE_BOTH |=> rd_sel.conv0 && !rd_sel.conv1) // [R4]
		else $error("both page read not conv0");
	a_intf_resv: assert property (req.rd && hit_intf |=> rdata[7:2] == 6'h00) // [R6]
		else $error("intf reserved bits nonzero");
	a_unmapped_zero: assert property (req.rd && !mapped |=> rdata == ZERO_BYTE) // [R6]
		else $error("unmapped read nonzero");
	a_pid_low: assert property (req.rd && req.addr == OFF_PID_LO |=> // [R3]
		rdata == PID_LO_CODE)
		else $error("product id low read wrong");
	a_pid_high: assert property (req.rd && req.addr == OFF_PID_HI |=> // [R3]
		rdata == PID_HI_CODE)
		else $error("product id high read wrong");
	a_read_answer: assert property (req.rd |=> rvalid) // [R3]
		else $error("read not answered");
	a_read_quiet: assert property (!req.rd |=> !rvalid) // [R3]
		else $error("answer without read");

	// ==========================================================
	// Steering, soft reset and clock-enable hold checks
	a_conv0_only: assert property (paged && page_q == PAGE_CONV0 |=> // [R4]
		wr_sel == only_conv0 && rd_sel == only_conv0)
		else $error("conv0 page steered wrong");
	a_conv1_only: assert property (paged && page_q == PAGE_CONV1 |=> // [R4]
		wr_sel == only_conv1 && rd_sel == only_conv1)
		else $error("conv1 page steered wrong");
	a_unpaged_read: assert property (!paged |=> rd_sel == only_conv0) // [R5]
		else $error("unpaged read steered");
	a_page_write: assert property (req.wr && hit_page && sr_q != SR_DONE |=> // [R4]
		page_q == $past(req.wdata[1:0]))
		else $error("page field not written");
	a_srst_page: assert property (sr_q == SR_DONE |=> page_q == PAGE_RST) // [R2]
		else $error("soft reset left page field");
	a_srst_count: assert property (sr_q == SR_BUSY |-> sr_cnt_q != SRST_IDLE) // [R2]
		else $error("soft reset counter ran out while busy");
	// Own disable: the default one would mask exactly the frozen cycles
	a_hold_frozen: assert property (disable iff (rst) !clk_en |=> // [R1] [R4]
		$stable(rdata) && $stable(rvalid) && $stable(wr_sel) && $stable(rd_sel)
		&& $stable(serial_bit_order_select) && $stable(soft_reset_active))
		else $error("outputs moved while frozen");
endmodule

// [design/page_range_match.sv]
// Range comparator: flags an address inside one paged window.
// Assumes bounds are constants with lo not above hi.
`timescale 1ns/1ps
module page_range_match #(
	parameter logic [11:0] LO = 12'h000,
	parameter logic [11:0] HI = 12'h000
) (
	input wire logic [11:0] addr,
	output logic hit
);
	assign hit = (addr >= LO) && (addr <= HI);
endmodule

// [dv/host_model.sv]
// Host model: issues one-cycle register strobes as the serial port does.
// Assumes reset is released before the first call.
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	output cfg_regs_pkg::reg_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	import cfg_regs_pkg::*;
	initial req = '0;
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		// Released data goes stale on purpose
		req.wr <= 1'b0;
		req.wdata <= ~d;
		#1;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		d = rdata;
		v = rvalid;
	endtask
	task automatic point(input logic [11:0] a);
		@(posedge clk);
		req.addr <= a;
		@(posedge clk);
		#1;
	endtask
endmodule

// [dv/tb.sv]
// Bench for the config register group, driven through the host model.
// Assumes the design's pulse strobes and one-cycle read answer.
`timescale 1ns/1ps
module tb;
	import cfg_regs_pkg::*;
	localparam logic [7:0] CAT = 8'hC3; // arbitrary value
	localparam logic [7:0] PL = 8'h21; // arbitrary value
	localparam logic [7:0] PH = 8'h7E; // arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	reg_req_s req;
	logic [7:0] rdata;
	logic [7:0] d;
	logic rvalid;
	logic v;
	logic bit_order;
	logic busy;
	conv_sel_s wr_sel;
	conv_sel_s rd_sel;
	int n_fail = 0;
	int total_checks = 0;
	logic [11:0] in_pg [4] = '{PG0_LO, PG1_HI, PG2_LO, PG3_HI};
	always #50 clk = ~clk;
	host_model host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
	dac_config_id_paging_regs #(.CATEGORY_CODE(CAT), .PID_LO_CODE(PL), .PID_HI_CODE(PH),
		.GRADE_CODE(4'h3), .REVISION_CODE(4'hB)) dut (.clk(clk), .rst(rst), .clk_en(clk_en),
		.req(req), .rdata(rdata), .rvalid(rvalid), .serial_bit_order_select(bit_order),
		.soft_reset_active(busy), .wr_sel(wr_sel), .rd_sel(rd_sel));
	// ========================================
	// Compare helpers
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		host.rd(a, d, v);
		chk("rvalid", 8'h01, {7'h0, v});
		chk("rdata", e, d & m);
	endtask
	task automatic selchk(input logic [11:0] a, input logic [1:0] w, input logic [1:0] r);
		host.point(a);
		chk("wr_sel", {6'h0, w}, {6'h0, wr_sel});
		chk("rd_sel", {6'h0, r}, {6'h0, rd_sel});
	endtask
	// ========================================
	// Scenarios
	task automatic t_ident;
		host.wr(OFF_CATEGORY, ~CAT); // Must not stick
		rchk(PG1_LO, 8'hFF, ZERO_BYTE);
		rchk(OFF_CATEGORY, 8'hFF, CAT);
		rchk(OFF_PID_LO, 8'hFF, PL);
		rchk(OFF_PID_HI, 8'hFF, PH);
		rchk(OFF_GRADE_REV, 8'hFF, 8'h3B);
		$display("test ident done");
	endtask
	task automatic t_page;
		rchk(OFF_PAGE, 8'hFF, 8'h03);
		for (int p = 0; p < 4; p++) begin
			host.wr(OFF_PAGE, {6'h3F, p[1:0]});
			rchk(OFF_PAGE, 8'hFF, {6'h0, p[1:0]});
			selchk(in_pg[p], {p[0], p[1]}, (p == 2) ? 2'b01 : 2'b10);
			selchk(in_pg[p] + ((p % 2) ? 12'h001 : 12'hFFF), 2'b10, 2'b10);
		end
		$display("test page done");
	endtask
	task automatic t_order;
		host.wr(OFF_INTF_CFG, 8'h02);
		rchk(OFF_INTF_CFG, 8'h03, 8'h02);
		chk("bit_order", 8'h01, {7'h0, bit_order});
		host.wr(OFF_INTF_CFG, 8'h00);
		rchk(OFF_INTF_CFG, 8'h03, 8'h00);
		chk("bit_order", 8'h00, {7'h0, bit_order});
		$display("test order done");
	endtask
	task automatic t_soft;
		host.wr(OFF_PAGE, 8'h01);
		host.wr(OFF_INTF_CFG, 8'h01);
		chk("busy", 8'h01, {7'h0, busy});
		rchk(OFF_INTF_CFG, 8'h01, 8'h01);
		// Busy spans the counted cycles plus the done cycle
		repeat (2) @(posedge clk);
		#1;
		chk("busy", 8'h01, {7'h0, busy});
		@(posedge clk);
		#1;
		chk("busy", 8'h00, {7'h0, busy});
		rchk(OFF_INTF_CFG, 8'h01, 8'h00);
		rchk(OFF_PAGE, 8'hFF, 8'h03);
		$display("test soft done");
	endtask
	task automatic t_hold;
		host.wr(OFF_INTF_CFG, 8'h02);
		host.wr(OFF_PAGE, 8'h02);
		@(posedge clk);
		clk_en <= 1'b0;
		host.wr(OFF_PAGE, 8'h01); // Frozen, must not land
		@(posedge clk);
		clk_en <= 1'b1;
		rchk(OFF_PAGE, 8'hFF, 8'h02);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rchk(OFF_PAGE, 8'hFF, 8'h03);
		chk("bit_order", 8'h00, {7'h0, bit_order});
		$display("test hold done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#(3000 * 100);
		n_fail++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_ident();
		t_page();
		t_order();
		t_soft();
		t_hold();
		final_report();
	end
endmodule
